// file: logic/bsr_pkg.sv
package bsr_pkg;

    localparam int unsigned RESULT_W      = 24;
    localparam int unsigned CNT_W         = 6;
    localparam int unsigned TMR_W         = 24;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PD_HIGH_US    = 60;
    localparam int unsigned PD_HIGH_CYC   = PD_HIGH_US * CLK_MHZ;
    localparam int unsigned RATE_LO_SPS   = 10;
    localparam int unsigned RATE_HI_SPS   = 80;
    localparam int unsigned INT_LO_CYC    = CLK_MHZ * 1000000 / RATE_LO_SPS;
    localparam int unsigned INT_HI_CYC    = CLK_MHZ * 1000000 / RATE_HI_SPS;
    localparam int unsigned EXT_LO_DIV    = 1105920;
    localparam int unsigned EXT_HI_DIV    = 138240;
    localparam int unsigned SETTLE_LO_MS  = 400;
    localparam int unsigned SETTLE_HI_MS  = 50;
    localparam logic [2:0]  SETTLE_CONV   = 3'(SETTLE_LO_MS * RATE_LO_SPS / 1000);
    localparam int unsigned EXT_IDLE_NS   = 1000;
    localparam logic [6:0]  EXT_IDLE_CYC  = 7'(EXT_IDLE_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PULSES_A128 = 6'h19;
    localparam logic [CNT_W-1:0] PULSES_B32  = 6'h1a;
    localparam logic [CNT_W-1:0] PULSES_A64  = 6'h1b;
    localparam logic [CNT_W-1:0] BITS_LAST   = 6'h18;
    localparam logic [RESULT_W-1:0] SAT_MAX  = 24'h7fffff;
    localparam logic [RESULT_W-1:0] SAT_MIN  = 24'h800000;
    localparam logic DOUT_IDLE = 1'b1;

    typedef enum logic [2:0] {
        BSR_GAIN_A128 = 3'b001,
        BSR_GAIN_B32  = 3'b010,
        BSR_GAIN_A64  = 3'b100
    } bsr_gain_t;

    typedef struct packed {
        logic      chan_b;
        bsr_gain_t gain;
    } bsr_setting_t;

    localparam bsr_setting_t SETTING_RST = '{chan_b: 1'b0, gain: BSR_GAIN_A128};

    typedef enum logic [2:0] {
        ST_WAIT  = 3'b001,
        ST_READY = 3'b010,
        ST_PDOWN = 3'b100
    } bsr_state_t;

    typedef struct packed {
        logic powered_down;
        logic osc_enable;
        logic settled;
        logic comm_error;
    } bsr_status_t;

    function automatic logic [CNT_W-1:0] bsr_gray2bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b = g;
        for (int i = CNT_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic bsr_setting_t bsr_decode(input logic [CNT_W-1:0] n,
                                                input bsr_setting_t old);
        bsr_setting_t s;
        s = old;
        case (n)
            PULSES_A128: s = '{chan_b: 1'b0, gain: BSR_GAIN_A128};
            PULSES_B32:  s = '{chan_b: 1'b1, gain: BSR_GAIN_B32};
            PULSES_A64:  s = '{chan_b: 1'b0, gain: BSR_GAIN_A64};
            default:     s = old;
        endcase
        return s;
    endfunction

endpackage

// file: logic/bsr_readout.sv
`timescale 1ns/1ps
module bsr_readout
    import bsr_pkg::*;
#(
    parameter int unsigned      SAMPLE_W   = 28,
    parameter logic [TMR_W-1:0] INT_LO     = TMR_W'(INT_LO_CYC),
    parameter logic [TMR_W-1:0] INT_HI     = TMR_W'(INT_HI_CYC),
    parameter logic [TMR_W-1:0] EXT_LO     = TMR_W'(EXT_LO_DIV),
    parameter logic [TMR_W-1:0] EXT_HI     = TMR_W'(EXT_HI_DIV),
    parameter logic [12:0]      PD_CYC     = 13'(PD_HIGH_CYC)
)
(
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       powerdown_serial_clock_in,
    input  wire logic                       osc_clock_input_pin,
    input  wire logic                       rate_sel_in,
    input  wire logic signed [SAMPLE_W-1:0] sample_in,
    output logic                            data_out,
    output logic                            crystal_drive_pin,
    output bsr_setting_t                    setting,
    output bsr_status_t                     status
);

    // ------------------------------------------------------------
    // Link domain: pulse counter on the serial clock
    // ------------------------------------------------------------
    // The serial clock stops between readouts, so this side only counts.
    // The gray count crosses safely because it moves one bit per pulse.
    logic [CNT_W-1:0] lnk_bin_q;
    logic [CNT_W-1:0] lnk_bin_d;
    logic [CNT_W-1:0] lnk_gray_q;
    logic [CNT_W-1:0] lnk_gray_d;

    always_comb
    begin
        lnk_bin_d  = lnk_bin_q + 6'h01;
        lnk_gray_d = lnk_bin_d ^ (lnk_bin_d >> 1);
    end

    always_ff @(posedge powerdown_serial_clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lnk_bin_q  <= '0;
            lnk_gray_q <= '0;
        end
        else
        begin
            lnk_bin_q  <= lnk_bin_d;
            lnk_gray_q <= lnk_gray_d;
        end
    end

    // ------------------------------------------------------------
    // Synchronisers into mclk
    // ------------------------------------------------------------
    logic [CNT_W-1:0] gray_s1_q;
    logic [CNT_W-1:0] gray_s2_q;
    logic             sck_s1_q;
    logic             sck_s2_q;
    logic             xi_s1_q;
    logic             xi_s2_q;
    logic             xi_s3_q;
    logic             rate_s1_q;
    logic             rate_s2_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gray_s1_q <= '0;
            gray_s2_q <= '0;
            sck_s1_q  <= 1'b0;
            sck_s2_q  <= 1'b0;
            xi_s1_q   <= 1'b0;
            xi_s2_q   <= 1'b0;
            xi_s3_q   <= 1'b0;
            rate_s1_q <= 1'b0;
            rate_s2_q <= 1'b0;
        end
        else
        begin
            gray_s1_q <= lnk_gray_q;
            gray_s2_q <= gray_s1_q;
            sck_s1_q  <= powerdown_serial_clock_in;
            sck_s2_q  <= sck_s1_q;
            xi_s1_q   <= osc_clock_input_pin;
            xi_s2_q   <= xi_s1_q;
            xi_s3_q   <= xi_s2_q;
            rate_s1_q <= rate_sel_in;
            rate_s2_q <= rate_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Clock source and conversion timer
    // ------------------------------------------------------------
    logic             xi_edge;
    logic             ext_act_q;
    logic             ext_act_d;
    logic [6:0]       idle_q;
    logic [6:0]       idle_d;
    logic             rate_q;
    logic             src_q;
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] tmr_d;
    logic [TMR_W-1:0] period;
    logic             tb_ev;
    logic             tick;
    logic             osc_en_d;
    logic             xdrv_d;
    bsr_state_t       state_q;
    bsr_state_t       state_d;

    always_comb
    begin
        xi_edge   = xi_s2_q & ~xi_s3_q;
        ext_act_d = ext_act_q;
        idle_d    = idle_q;
        if (xi_edge)
        begin
            idle_d    = '0;
            ext_act_d = 1'b1;
        end
        else if (idle_q == EXT_IDLE_CYC - 7'h01)
        begin
            ext_act_d = 1'b0;
        end
        else
        begin
            idle_d = idle_q + 7'h01;
        end
        osc_en_d = ~ext_act_d;
        xdrv_d   = ext_act_d & ~xi_s2_q;
        tb_ev    = ext_act_q ? xi_edge : 1'b1;
        if (ext_act_q)
        begin
            period = rate_s2_q ? EXT_HI : EXT_LO;
        end
        else
        begin
            period = rate_s2_q ? INT_HI : INT_LO;
        end
        tick  = tb_ev && (tmr_q == period - 24'h000001);
        tmr_d = tmr_q;
        if (rate_q != rate_s2_q || src_q != ext_act_q || state_q == ST_PDOWN || tick)
        begin
            tmr_d = '0;
        end
        else if (tb_ev)
        begin
            tmr_d = tmr_q + 24'h000001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_act_q         <= 1'b0;
            idle_q            <= '0;
            rate_q            <= 1'b0;
            src_q             <= 1'b0;
            tmr_q             <= '0;
            crystal_drive_pin <= 1'b0;
        end
        else
        begin
            ext_act_q         <= ext_act_d;
            idle_q            <= idle_d;
            rate_q            <= rate_s2_q;
            src_q             <= ext_act_q;
            tmr_q             <= tmr_d;
            crystal_drive_pin <= xdrv_d;
        end
    end

    // ------------------------------------------------------------
    // Readout, setting and power-down control
    // ------------------------------------------------------------
    function automatic logic [RESULT_W-1:0] sat(input logic signed [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-RESULT_W:0] hi;
        hi = s[SAMPLE_W-1:RESULT_W-1];
        if ((&hi) || !(|hi))
        begin
            return s[RESULT_W-1:0];
        end
        return s[SAMPLE_W-1] ? SAT_MIN : SAT_MAX;
    endfunction

    logic [CNT_W-1:0] cnt_now;
    logic [CNT_W-1:0] base_q;
    logic [CNT_W-1:0] base_d;
    logic [CNT_W-1:0] delta;
    logic [RESULT_W-1:0] result_q;
    logic [RESULT_W-1:0] result_d;
    logic [12:0]      hi_q;
    logic [12:0]      hi_d;
    logic [2:0]       settle_q;
    logic [2:0]       settle_d;
    logic             pd_enter;
    logic             dout_d;
    logic             err_d;
    logic             load;
    logic             cur_bit;
    bsr_setting_t     set_d;

    always_comb
    begin
        cnt_now  = bsr_gray2bin(gray_s2_q);
        delta    = cnt_now - base_q;
        cur_bit  = result_q[5'(6'd24 - delta)];
        hi_d     = sck_s2_q ? ((hi_q == PD_CYC) ? hi_q : hi_q + 13'h0001) : '0;
        pd_enter = sck_s2_q && (hi_q == PD_CYC - 13'h0001);
        state_d  = state_q;
        base_d   = base_q;
        result_d = result_q;
        set_d    = setting;
        settle_d = settle_q;
        err_d    = status.comm_error;
        load     = 1'b0;
        case (state_q)
            ST_WAIT:
            begin
                load = tick;
            end
            ST_READY:
            begin
                if (tick && (delta == '0 || delta > BITS_LAST))
                begin
                    load  = 1'b1;
                    set_d = bsr_decode(delta, setting);
                    err_d = (delta > PULSES_A64);
                end
            end
            ST_PDOWN:
            begin
                if (!sck_s2_q)
                begin
                    state_d  = ST_WAIT;
                    base_d   = cnt_now;
                    settle_d = '0;
                end
            end
            default:
            begin
                state_d = ST_WAIT;
            end
        endcase
        if (load)
        begin
            state_d  = ST_READY;
            base_d   = cnt_now;
            result_d = sat(sample_in);
            if (set_d != setting)
            begin
                settle_d = '0;
            end
            else if (settle_q != SETTLE_CONV)
            begin
                settle_d = settle_q + 3'h1;
            end
        end
        if (pd_enter)
        begin
            state_d = ST_PDOWN;
            set_d   = setting;
        end
        dout_d = DOUT_IDLE;
        if (state_q == ST_READY)
        begin
            if (delta == '0)
            begin
                dout_d = 1'b0;
            end
            else if (delta <= BITS_LAST)
            begin
                dout_d = cur_bit;
            end
            else
            begin
                dout_d = DOUT_IDLE;
            end
        end
    end

    // Power-on reset is the only reset of the whole block.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q             <= ST_WAIT;
            base_q              <= '0;
            result_q            <= '0;
            hi_q                <= '0;
            settle_q            <= '0;
            setting             <= SETTING_RST;
            data_out            <= DOUT_IDLE;
            status.comm_error   <= 1'b0;
            status.settled      <= 1'b0;
            status.powered_down <= 1'b0;
            status.osc_enable   <= 1'b1;
        end
        else
        begin
            state_q             <= state_d;
            base_q              <= base_d;
            result_q            <= result_d;
            hi_q                <= hi_d;
            settle_q            <= settle_d;
            setting             <= set_d;
            data_out            <= dout_d;
            status.comm_error   <= err_d;
            status.settled      <= (settle_d == SETTLE_CONV);
            status.powered_down <= (state_d == ST_PDOWN);
            status.osc_enable   <= osc_en_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_idle_dout_high: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_WAIT |=> data_out)
        else $error("Data output not high while no result waits.");

    chk_ready_dout_low: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_READY && delta == '0 && !pd_enter |=> !data_out)
        else $error("Data output not low with a result waiting.");

    chk_bit_order: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_READY && delta != '0 && delta <= BITS_LAST && !pd_enter
        |=> data_out == $past(cur_bit))
        else $error("Wrong result bit on the data output.");

    chk_end_high: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_READY && delta > BITS_LAST && !pd_enter |=> data_out)
        else $error("Data output not high after the last bit.");

    chk_select_b32: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_READY && tick && delta == PULSES_B32 && !pd_enter
        |=> setting.chan_b && setting.gain == BSR_GAIN_B32)
        else $error("26 pulses did not select channel B gain 32.");

    chk_sat_high: assert property (@(posedge mclk) disable iff (!rst_n)
        load && !pd_enter && !sample_in[SAMPLE_W-1]
        && sample_in[SAMPLE_W-2:RESULT_W-1] != '0 |=> result_q == SAT_MAX)
        else $error("Positive overrange not saturated.");

    chk_pd_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        sck_s2_q && hi_q == PD_CYC |-> state_q == ST_PDOWN && status.powered_down)
        else $error("Long serial clock high did not power down.");

    chk_pd_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_PDOWN |=> $stable(setting))
        else $error("Setting changed during power-down.");

    chk_pd_exit: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_PDOWN && !sck_s2_q |=> state_q == ST_WAIT ##1 !status.powered_down)
        else $error("Low serial clock did not resume normal mode.");

    chk_settle_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(setting) |-> !status.settled [*2])
        else $error("Settled flag up right after a setting change.");

    chk_osc_off: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(ext_act_q) |=> !status.osc_enable)
        else $error("Internal oscillator left on with external clock.");

endmodule

// file: tb/bsr_host_model.sv
`timescale 1ns/1ps
module bsr_host_model
(
    output logic      sck,
    input  wire logic data_out
);
    // ------------------------------------------------------------
    // Host serial clock and bit capture
    // ------------------------------------------------------------
    // The clock stands low between frames.
    // Bits are taken at the end of the low phase, because the device answers some tens of
    // nanoseconds after each rising edge.
    localparam int HALF_NS = 24;

    initial
    begin
        sck = 1'b0;
    end

    task automatic wait_ready(input int limit_ns, output logic seen);
        repeat (limit_ns)
        begin
            if (data_out === 1'b0)
            begin
                break;
            end
            #1;
        end
        seen = (data_out === 1'b0);
    endtask

    task automatic read_frame(input int pulses, output logic [23:0] word, output logic tail);
        word = 24'h000000;
        tail = 1'b0;
        for (int i = 1; i <= pulses; i++)
        begin
            sck = 1'b1;
            #(HALF_NS);
            sck = 1'b0;
            #(HALF_NS - 1);
            if (i <= 24)
            begin
                word = {word[22:0], data_out};
            end
            else if (i == 25)
            begin
                tail = data_out;
            end
            #1;
        end
    endtask

    task automatic hold_high(input int ns);
        sck = 1'b1;
        #(ns);
        sck = 1'b0;
    endtask
endmodule

// file: tb/bsr_readout_test.sv
`timescale 1ns/1ps
module bsr_readout_test
    import bsr_pkg::*;
;
    logic               mclk;
    logic               rst_n;
    logic               xi;
    logic               xi_run;
    logic               rate;
    logic signed [27:0] sample;
    logic signed [27:0] nxt;
    logic signed [27:0] corner [6];
    logic               sck;
    logic               data_out;
    logic               xo;
    logic               seen;
    bsr_setting_t       setting;
    bsr_setting_t       want;
    bsr_status_t        status;
    int                 miscompares;
    int                 check_count;
    int                 n;
    int                 run;
    time                tr;
    time                dt;

    bsr_readout #(
        .INT_LO (24'h0000c8),
        .INT_HI (24'h000064),
        .EXT_LO (24'h000028),
        .PD_CYC (13'h012c)
    ) uut (
        .mclk                      (mclk),
        .rst_n                     (rst_n),
        .powerdown_serial_clock_in (sck),
        .osc_clock_input_pin       (xi),
        .rate_sel_in               (rate),
        .sample_in                 (sample),
        .data_out                  (data_out),
        .crystal_drive_pin         (xo),
        .setting                   (setting),
        .status                    (status)
    );

    bsr_host_model host (
        .sck      (sck),
        .data_out (data_out)
    );

    // ------------------------------------------------------------
    // Clocks and expectations
    // ------------------------------------------------------------
    always #5 mclk = ~mclk;
    // The external clock toggles on falling system clock edges; it rests low when stopped.
    always #50 xi = xi_run ? ~xi : 1'b0;

    function automatic logic [23:0] sat24(input logic signed [27:0] s);
        if (s > 28'sh07fffff) return 24'h7fffff;
        if (s < 28'shf800000) return 24'h800000;
        return s[23:0];
    endfunction

    function automatic bsr_setting_t exp_setting(input int p, input bsr_setting_t old);
        case (p)
            25: return '{chan_b: 1'b0, gain: BSR_GAIN_A128};
            26: return '{chan_b: 1'b1, gain: BSR_GAIN_B32};
            27: return '{chan_b: 1'b0, gain: BSR_GAIN_A64};
            default: return old;
        endcase
    endfunction

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %06h seen %06h", what, exp, got);
        end
    endtask

    task automatic check_set(input string what, input bsr_setting_t exp, input bsr_setting_t got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic get_ready;
        host.wait_ready(30000, seen);
        check_bit("ready", 1'b1, seen);
    endtask

    // The next sample is applied mid-readout, where a tick is skipped, so the loaded value
    // never races the change.
    task automatic do_frame(input int p, input logic signed [27:0] nv);
        logic [23:0] w;
        logic        tail;
        logic [23:0] exp_w;
        exp_w = sat24(sample);
        fork
            host.read_frame(p, w, tail);
            begin
                #300;
                @(negedge mclk) sample = nv;
            end
        join
        check_word("result", exp_w, w);
        if (p >= 25)
            check_bit("tail", 1'b1, tail);
    endtask

    initial
    begin
        #500000;
        miscompares++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        xi = 1'b0;
        xi_run = 1'b0;
        rate = 1'b0;
        sample = 28'sh0000000;
        corner = '{28'sh07fffff, 28'sh0800000, 28'shf800000, 28'shf7fffff, 28'sh7ffffff,
                   28'sh8000000};
        void'($urandom(13));
        repeat (6) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        check_bit("idle dout", 1'b1, data_out);
        check_set("reset setting", '{chan_b: 1'b0, gain: BSR_GAIN_A128}, setting);
        check_bit("reset pd", 1'b0, status.powered_down);
        check_bit("reset osc", 1'b1, status.osc_enable);
        check_bit("reset xo", 1'b0, xo);
        want = '{chan_b: 1'b0, gain: BSR_GAIN_A128};
        run = 0;
        get_ready();
        tr = $time;
        for (int f = 0; f < 16; f++)
        begin
            n = (f < 3) ? 25 + f : (f < 9) ? 25 + int'($urandom_range(2)) : 26;
            nxt = (f < 6) ? corner[f] : 28'($urandom);
            if (exp_setting(n, want) !== want)
                run = 0;
            want = exp_setting(n, want);
            run++;
            do_frame(n, nxt);
            get_ready();
            dt = $time - tr;
            tr = $time;
            check_bit("rate low period", 1'b1, dt >= 1980 && dt <= 2020);
            check_set("setting", want, setting);
            check_bit("comm ok", 1'b0, status.comm_error);
            if (run == 1 && f > 0)
                check_bit("settle drop", 1'b0, status.settled);
            if (run >= 5)
                check_bit("settled", 1'b1, status.settled);
        end
        do_frame(30, 28'sh0123456);
        get_ready();
        check_bit("comm error", 1'b1, status.comm_error);
        check_set("kept", want, setting);
        @(negedge mclk) rate = 1'b1;
        sample = 28'shfedcba9;
        repeat (110) @(negedge mclk);
        do_frame(25, 28'sh0000321);
        want = exp_setting(25, want);
        get_ready();
        check_bit("comm clear", 1'b0, status.comm_error);
        @(negedge mclk) rate = 1'b0;
        xi_run = 1'b1;
        repeat (20) @(negedge mclk);
        check_bit("osc off", 1'b0, status.osc_enable);
        @(posedge xi);
        repeat (4) @(negedge mclk);
        check_bit("xo high phase", 1'b0, xo);
        @(negedge xi);
        repeat (4) @(negedge mclk);
        check_bit("xo low phase", 1'b1, xo);
        get_ready();
        do_frame(25, 28'sh0055aa5);
        get_ready();
        tr = $time;
        do_frame(25, 28'shffaa55a);
        get_ready();
        dt = $time - tr;
        check_bit("ext period", 1'b1, dt >= 3970 && dt <= 4030);
        xi_run = 1'b0;
        repeat (130) @(negedge mclk);
        check_bit("osc back", 1'b1, status.osc_enable);
        check_bit("xo rest", 1'b0, xo);
        // The new setting is applied at a tick before power-down so that it is retained.
        do_frame(27, 28'sh0000777);
        want = exp_setting(27, want);
        get_ready();
        check_set("before pd", want, setting);
        fork
            host.hold_high(4000);
            begin
                #2500;
                check_bit("pd early", 1'b0, status.powered_down);
                #1400;
                check_bit("pd entered", 1'b1, status.powered_down);
            end
        join
        repeat (10) @(negedge mclk);
        check_bit("pd left", 1'b0, status.powered_down);
        check_set("pd kept", want, setting);
        get_ready();
        do_frame(27, 28'sh0000000);
        get_ready();
        check_set("after pd", want, setting);
        print_verdict();
    end
endmodule
